// ==== verilog/eac_top.sv ====
// Nonvolatile memory access control with its byte array and registers.
//
// How it works
// RULE1: Nine-bit address picks bytes 0 to 511.
// RULE2: Reserved address and control bits read zero.
// RULE3: Software loads an address before any access.
// RULE4: Write stores data byte at selected address.
// RULE5: Read places addressed byte in data register.
// RULE6: Ready interrupt needs enable and global flag.
// RULE7: Ready interrupt is a level while idle.
// RULE8: Strobe within four cycles of arm writes.
// RULE9: Strobe without arm does nothing.
// RULE10: Arm bit clears itself after four cycles.
// RULE11: Strobe after arm, address and data prepared.
// RULE12: Read strobe gives data within one instruction.
// RULE13: Read stalls the core four cycles.
// RULE14: Write strobe clears when write time elapses.
// RULE15: Write lasts 27072 oscillator cycles.
// RULE16: Write start stalls the core two cycles.
// RULE17: No reads or address changes while writing.
// RULE18: Read strobe clears itself after the read.
// RULE19: Strobe during a running write is ignored.
`include "eac_defs.svh"
`timescale 1ns/1ns
module eac_top #(
    parameter int WRITE_RC_CYCLES = `EAC_WRITE_RC_CYC
) (
    input  wire logic            clk_i,      // System clock, 50 MHz.
    input  wire logic            reset_n_i,  // Asynchronous reset.
    input  wire eac_pkg::eac_io_t io_i,      // Core register access.
    input  wire logic            gie_i,      // Core global irq flag.
    input  wire logic            rc_tick_i,  // One pulse per RC cycle.
    output logic [7:0]           io_rdata_o, // Register read data.
    output logic                 stall_o,    // Halts the core.
    output logic                 ready_irq_o // Ready interrupt level.
);
    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [7:0]              mem [`EAC_DEPTH];
    eac_pkg::eac_ctl_t       ctl_ff;
    eac_pkg::eac_state_t     state_ff;
    logic [`EAC_AW-1:0]      addr_ff;
    logic [7:0]              data_ff;
    logic [`EAC_AW-1:0]      wr_addr_ff;
    logic [7:0]              wr_data_ff;
    logic [2:0]              arm_cnt_ff;
    logic [2:0]              stall_cnt_ff;
    logic [14:0]             rc_cnt_ff;
    logic [7:0]              rdata_ff;
    logic                    busy;
    logic                    ctl_wr;
    logic                    arm_wr;
    logic                    strobe_wr;
    logic                    rd_go;
    logic                    wr_go;
    logic                    wr_done;
    logic                    arm_end;

    localparam logic [14:0] RC_LAST = 15'(WRITE_RC_CYCLES - 1);

    assign busy      = (state_ff == eac_pkg::EAC_PROG);
    assign ctl_wr    = io_i.wr && (io_i.addr == `EAC_OFS_CTRL);
    assign arm_wr    = ctl_wr && io_i.wdata[`EAC_BIT_ARM];
    assign strobe_wr = ctl_wr && io_i.wdata[`EAC_BIT_WR];
    assign rd_go     = ctl_wr && io_i.wdata[`EAC_BIT_RD] && !busy; // RULE17
    // Arm must already stand; a write running blocks a new one.
    assign wr_go     = strobe_wr && ctl_ff.master_write_arm
                       && !busy; // RULE8 RULE9 RULE19
    assign wr_done   = busy && rc_tick_i && (rc_cnt_ff == RC_LAST); // RULE15
    assign arm_end   = ctl_ff.master_write_arm && (arm_cnt_ff == 3'h1);

    // ----------------------------------------------------------------
    // Address register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_ff <= `EAC_RST_ADDR;
        end else if (io_i.wr && !busy) begin // RULE17
            if (io_i.addr == `EAC_OFS_ADDR_LO) begin
                addr_ff[7:0] <= io_i.wdata; // RULE1
            end else if (io_i.addr == `EAC_OFS_ADDR_HI) begin
                addr_ff[8] <= io_i.wdata[0]; // RULE1
            end
        end
    end

    // ----------------------------------------------------------------
    // Data register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_ff <= `EAC_RST_BYTE;
        end else if (rd_go) begin
            data_ff <= mem[addr_ff]; // RULE5 RULE12
        end else if (io_i.wr && (io_i.addr == `EAC_OFS_DATA)) begin
            data_ff <= io_i.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Control bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_ff.ready_irq_enable <= 1'b0;
        end else if (ctl_wr) begin
            ctl_ff.ready_irq_enable <= io_i.wdata[`EAC_BIT_RIE]; // RULE6
        end
    end

    // A fresh arm write wins over the timeout in the same cycle.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_ff.master_write_arm <= 1'b0;
            arm_cnt_ff              <= 3'h0;
        end else if (arm_wr && !ctl_ff.master_write_arm) begin
            ctl_ff.master_write_arm <= 1'b1;
            arm_cnt_ff              <= `EAC_ARM_CYCLES;
        end else if (arm_end) begin
            ctl_ff.master_write_arm <= arm_wr; // RULE10
            arm_cnt_ff              <= arm_wr ? `EAC_ARM_CYCLES : 3'h0;
        end else if (ctl_ff.master_write_arm) begin
            arm_cnt_ff <= arm_cnt_ff - 3'h1; // RULE10
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_ff.write_strobe <= 1'b0;
        end else if (wr_go) begin
            ctl_ff.write_strobe <= 1'b1; // RULE11
        end else if (wr_done) begin
            ctl_ff.write_strobe <= 1'b0; // RULE14
        end
    end

    // The read finishes in the strobe cycle, so the bit drops next edge.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_ff.read_strobe <= 1'b0;
        end else begin
            ctl_ff.read_strobe <= rd_go; // RULE18
        end
    end

    // ----------------------------------------------------------------
    // Write sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff   <= eac_pkg::EAC_IDLE;
            rc_cnt_ff  <= 15'h0000;
            wr_addr_ff <= `EAC_RST_ADDR;
            wr_data_ff <= `EAC_RST_BYTE;
        end else begin
            case (state_ff)
                eac_pkg::EAC_IDLE: begin
                    if (wr_go) begin
                        state_ff   <= eac_pkg::EAC_PROG;
                        rc_cnt_ff  <= 15'h0000;
                        wr_addr_ff <= addr_ff; // RULE4
                        wr_data_ff <= data_ff; // RULE4
                    end
                end
                eac_pkg::EAC_PROG: begin
                    if (wr_done) begin
                        state_ff <= eac_pkg::EAC_IDLE;
                    end else if (rc_tick_i) begin
                        rc_cnt_ff <= rc_cnt_ff + 15'h0001; // RULE15
                    end
                end
                default: begin
                    state_ff <= eac_pkg::EAC_IDLE;
                end
            endcase
        end
    end

    // The array has no reset; its content survives a reset.
    always_ff @(posedge clk_i) begin
        if (wr_done) begin
            mem[wr_addr_ff] <= wr_data_ff; // RULE4
        end
    end

    // ----------------------------------------------------------------
    // Core stall
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stall_cnt_ff <= 3'h0;
        end else if (rd_go) begin
            stall_cnt_ff <= `EAC_READ_STALL; // RULE13
        end else if (wr_go) begin
            stall_cnt_ff <= `EAC_WRITE_STALL; // RULE16
        end else if (stall_cnt_ff != 3'h0) begin
            stall_cnt_ff <= stall_cnt_ff - 3'h1;
        end
    end

    assign stall_o = (stall_cnt_ff != 3'h0);

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_ff <= `EAC_RST_BYTE;
        end else if (io_i.rd) begin
            case (io_i.addr)
                `EAC_OFS_CTRL:    rdata_ff <= {4'h0, ctl_ff}; // RULE2
                `EAC_OFS_DATA:    rdata_ff <= data_ff;
                `EAC_OFS_ADDR_LO: rdata_ff <= addr_ff[7:0];
                `EAC_OFS_ADDR_HI: rdata_ff <= {7'h00, addr_ff[8]}; // RULE2
                default:          rdata_ff <= `EAC_RST_BYTE;
            endcase
        end
    end

    assign io_rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // Ready interrupt
    // ----------------------------------------------------------------
    assign ready_irq_o = ctl_ff.ready_irq_enable && gie_i
                         && !ctl_ff.write_strobe; // RULE6 RULE7

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_arm_window;
        ctl_ff.master_write_arm [*4];
    endsequence

    sequence s_read_halt;
        stall_o [*4] ##1 !stall_o;
    endsequence

    sequence s_write_halt;
        stall_o [*2] ##1 !stall_o;
    endsequence

    chk_arm_timeout: assert property ( // RULE10
        $rose(ctl_ff.master_write_arm) |-> s_arm_window
        ##1 (!ctl_ff.master_write_arm || $past(arm_wr)))
        else $error("arm bit did not time out after four cycles");

    chk_strobe_unarmed: assert property ( // RULE9
        strobe_wr && !ctl_ff.master_write_arm && !busy |=> !busy)
        else $error("unarmed strobe started a write");

    chk_strobe_armed: assert property ( // RULE8
        strobe_wr && ctl_ff.master_write_arm && !busy
        |=> busy && ctl_ff.write_strobe)
        else $error("armed strobe did not start a write");

    chk_read_stall: assert property ( // RULE13
        rd_go |=> s_read_halt)
        else $error("read stall not four cycles");

    chk_write_stall: assert property ( // RULE16
        wr_go |=> s_write_halt)
        else $error("write stall not two cycles");

    chk_read_data: assert property ( // RULE5
        rd_go |=> data_ff == mem[$past(addr_ff)])
        else $error("data register lacks fetched byte");

    chk_write_commit: assert property ( // RULE4
        wr_done |=> mem[$past(wr_addr_ff)] == $past(wr_data_ff)
        && !ctl_ff.write_strobe)
        else $error("write did not commit or strobe stayed set");

    chk_addr_frozen: assert property ( // RULE17
        busy && io_i.wr |=> $stable(addr_ff))
        else $error("address changed during a write");

    chk_no_restart: assert property ( // RULE19
        busy && strobe_wr |=> !busy || ($stable(wr_addr_ff)
        && $stable(wr_data_ff) && rc_cnt_ff >= $past(rc_cnt_ff)))
        else $error("running write restarted");

    chk_irq_level: assert property ( // RULE7
        ctl_ff.ready_irq_enable && gie_i && !busy
        && !$past(wr_go) |-> ready_irq_o)
        else $error("ready interrupt missing while idle");

    chk_irq_busy: assert property ( // RULE6
        busy || !gie_i |-> !ready_irq_o)
        else $error("ready interrupt while busy or globally off");

    chk_read_clear: assert property ( // RULE18
        ctl_ff.read_strobe |=> !ctl_ff.read_strobe || $past(rd_go))
        else $error("read strobe did not clear");

    chk_reserved_zero: assert property ( // RULE2
        io_i.rd && io_i.addr == `EAC_OFS_CTRL |=> io_rdata_o[7:4] == 4'h0)
        else $error("reserved control bits not zero");

endmodule

// ==== verilog/eac_defs.svh ====
// Offsets, field positions, reset values and timing counts of the block.
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH
`define EAC_OFS_CTRL       6'h1F
`define EAC_OFS_DATA       6'h20
`define EAC_OFS_ADDR_LO    6'h21
`define EAC_OFS_ADDR_HI    6'h22
`define EAC_BIT_RD         0
`define EAC_BIT_WR         1
`define EAC_BIT_ARM        2
`define EAC_BIT_RIE        3
`define EAC_RST_BYTE       8'h00
`define EAC_RST_ADDR       9'h000
`define EAC_ARM_CYCLES     3'h4
`define EAC_READ_STALL     3'h4
`define EAC_WRITE_STALL    3'h2
`define EAC_WRITE_RC_CYC   27072
`define EAC_DEPTH          512
`define EAC_AW             9
`endif

// ==== verilog/eac_pkg.sv ====
// Types shared by the nonvolatile memory access block.
package eac_pkg;
    typedef enum logic [1:0] {
        EAC_IDLE = 2'b01,
        EAC_PROG = 2'b10
    } eac_state_t;
    typedef struct packed {
        logic ready_irq_enable;
        logic master_write_arm;
        logic write_strobe;
        logic read_strobe;
    } eac_ctl_t;
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } eac_io_t;
endpackage

// ==== test/eac_cpu_model.sv ====
// Core-side model that issues register accesses to the block.
`include "eac_defs.svh"
`timescale 1ns/1ns
module eac_cpu_model (
    input  wire logic        clk_i,   // System clock.
    input  wire logic        stall_i, // Core halt from the block.
    input  wire logic [7:0]  rdata_i, // Register read data.
    output eac_pkg::eac_io_t io_o,    // Register access request.
    output logic             gie_o    // Global interrupt flag.
);
    initial begin
        io_o  = '0;
        gie_o = 1'b0;
    end
    // ------------------------------------------------------------
    // Register accesses
    // ------------------------------------------------------------
    // The core never issues an access while it is halted.
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        @(negedge clk_i);
        while (stall_i === 1'b1) @(negedge clk_i);
        io_o <= {a, d, w, ~w};
        @(negedge clk_i);
        io_o <= '0;
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        acc(1'b0, a, 8'h00);
        d = rdata_i;
    endtask
    task automatic set_addr(input logic [8:0] a);
        wr_reg(`EAC_OFS_ADDR_LO, a[7:0]);
        wr_reg(`EAC_OFS_ADDR_HI, {7'h00, a[8]});
    endtask
    // Arms, waits gap idle cycles, then sets the write strobe.
    task automatic nvm_write(input logic [8:0] a, input logic [7:0] d,
                             input int gap, input logic ie);
        set_addr(a);
        wr_reg(`EAC_OFS_DATA, d);
        wr_reg(`EAC_OFS_CTRL, {4'h0, ie, 3'h4});
        repeat (gap) @(negedge clk_i);
        wr_reg(`EAC_OFS_CTRL, {4'h0, ie, 3'h2});
    endtask
    task automatic set_gie(input logic v);
        @(negedge clk_i);
        gie_o <= v;
    endtask
endmodule

// ==== test/eeprom_access_control_tb.sv ====
// Self-checking bench for the nonvolatile memory access block.
`include "eac_defs.svh"
`timescale 1ns/1ns
module eeprom_access_control_tb;
    localparam int RC_N = 8;
    localparam int T_MIN = 4 * RC_N - 3;
    localparam int T_MAX = 4 * RC_N;
    typedef struct {
        logic [8:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } eac_row_t;
    eac_row_t rows [4] = '{'{9'h000, 8'hA5, 8'hA5}, '{9'h1FF, 8'h5A, 8'h5A},
                          '{9'h100, 8'h3C, 8'h3C}, '{9'h0FF, 8'hC3, 8'hC3}};
    logic             clk_i      = 1'b0;
    logic             reset_n_i  = 1'b0;
    logic             rc_tick_i  = 1'b0;
    logic [1:0]       tick_cnt   = 2'h0;
    eac_pkg::eac_io_t io;
    logic             gie;
    logic [7:0]       rdata;
    logic             stall;
    logic             irq;
    logic [7:0]       rv;
    int               n;
    int               m;
    int               n_mismatch = 0;
    int               checked    = 0;
    always #10 clk_i = ~clk_i;
    // Oscillator tick: one pulse every four system cycles.
    always @(negedge clk_i) begin
        tick_cnt  <= tick_cnt + 2'h1;
        rc_tick_i <= (tick_cnt == 2'h3);
    end
    eac_top #(.WRITE_RC_CYCLES(RC_N)) dut_u (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .io_i(io), .gie_i(gie), .rc_tick_i(rc_tick_i),
        .io_rdata_o(rdata), .stall_o(stall), .ready_irq_o(irq));
    eac_cpu_model cpu_u (.clk_i(clk_i), .stall_i(stall), .rdata_i(rdata),
        .io_o(io), .gie_o(gie));
    // ------------------------------------------------------------
    // Checking tasks
    // ------------------------------------------------------------
    task automatic cmp8(input string s, input logic [7:0] e,
                        input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cmp1(input string s, input logic e, input logic g);
        cmp8(s, {7'h00, e}, {7'h00, g});
    endtask
    task automatic cmpn(input string s, input int e, input int g);
        checked++;
        if (g != e) begin
            n_mismatch++;
            $display("ERROR %s expected %0d seen %0d", s, e, g);
        end
    endtask
    task automatic count_stall(output int c);
        c = 0;
        while (stall === 1'b1 && c < 10) begin
            c++;
            @(negedge clk_i);
        end
    endtask
    task automatic wait_idle();
        int k = 0;
        rv = 8'h02;
        while (rv[1] !== 1'b0 && k < 100) begin
            cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
            k++;
        end
        cmp1("write done", 1'b0, rv[1]);
    endtask
    task automatic rd_byte(input logic [8:0] a, input logic [7:0] e);
        cpu_u.set_addr(a);
        cpu_u.wr_reg(`EAC_OFS_DATA, ~e);
        cpu_u.wr_reg(`EAC_OFS_CTRL, 8'h09);
        count_stall(n);
        cmpn("read stall", 4, n);
        cpu_u.rd_reg(`EAC_OFS_DATA, rv);
        cmp8("read byte", e, rv);
    endtask
    task automatic give_verdict();
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk_i);
        cmp1("irq in reset", 1'b0, irq);
        reset_n_i = 1'b1;
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp8("ctrl reset", 8'h00, rv);
        cpu_u.wr_reg(`EAC_OFS_ADDR_HI, 8'hFF);
        cpu_u.rd_reg(`EAC_OFS_ADDR_HI, rv);
        cmp8("addr high", 8'h01, rv);
        cpu_u.wr_reg(`EAC_OFS_CTRL, 8'hF0);
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp8("ctrl reserved", 8'h00, rv);
        cpu_u.rd_reg(6'h30, rv);
        cmp8("unmapped", 8'h00, rv);
        cpu_u.wr_reg(`EAC_OFS_CTRL, 8'h08);
        cmp1("irq no gie", 1'b0, irq);
        cpu_u.set_gie(1'b1);
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp1("irq idle", 1'b1, irq);
        cpu_u.wr_reg(`EAC_OFS_CTRL, 8'h00);
        cmp1("irq disabled", 1'b0, irq);
        foreach (rows[i]) begin
            cpu_u.nvm_write(rows[i].a, rows[i].d, 0, 1'b1);
            count_stall(n);
            cmpn("write stall", 2, n);
            m = 2;
            while (irq === 1'b0 && m < 102) begin
                m++;
                @(negedge clk_i);
            end
            cmp1("write time", 1'b1, m >= T_MIN && m <= T_MAX);
            cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
            cmp8("ctrl after write", 8'h08, rv);
            rd_byte(rows[i].a, rows[i].e);
            cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
            cmp8("read strobe clear", 8'h08, rv);
        end
        foreach (rows[i]) rd_byte(rows[i].a, rows[i].e);
        cpu_u.set_addr(9'h010);
        cpu_u.wr_reg(`EAC_OFS_CTRL, 8'h02);
        count_stall(n);
        cmpn("unarmed stall", 0, n);
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp8("unarmed strobe", 8'h00, rv);
        cpu_u.wr_reg(`EAC_OFS_CTRL, 8'h06);
        count_stall(n);
        cmpn("arm with strobe stall", 0, n);
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp8("arm with strobe", 8'h04, rv);
        cpu_u.nvm_write(9'h010, 8'h77, 3, 1'b0);
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp8("late strobe", 8'h00, rv);
        cpu_u.nvm_write(9'h010, 8'h66, 2, 1'b0);
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp8("last cycle strobe", 8'h02, rv);
        cpu_u.nvm_write(9'h055, 8'h11, 0, 1'b0);
        cpu_u.wr_reg(`EAC_OFS_CTRL, 8'h03);
        count_stall(n);
        cmpn("busy read stall", 0, n);
        cpu_u.rd_reg(`EAC_OFS_DATA, rv);
        cmp8("busy read data", 8'h11, rv);
        cpu_u.rd_reg(`EAC_OFS_ADDR_LO, rv);
        cmp8("busy address", 8'h10, rv);
        wait_idle();
        rd_byte(9'h010, 8'h66);
        @(negedge clk_i);
        reset_n_i = 1'b0;
        @(negedge clk_i);
        cmp1("irq mid reset", 1'b0, irq);
        reset_n_i = 1'b1;
        cpu_u.rd_reg(`EAC_OFS_CTRL, rv);
        cmp8("ctrl after reset", 8'h00, rv);
        give_verdict();
    end
endmodule
